// ---- tca_pkg.sv ----
// Purpose: Shared constants and types for the trip cause annunciator
// Assumes: 100 MHz system clock
// Notes: Display codes are four ASCII characters packed into 32 bits
package tca_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;          // System clock rate
  localparam int unsigned DEBOUNCE_MS = 20;       // Button settle time
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * 1000 * CLK_MHZ;
  localparam int unsigned OVERRIDE_MULT = 100;    // Override level, times rating

  // ---------------------------------------------------------------
  // Display codes
  // ---------------------------------------------------------------
  localparam logic [31:0] CODE_BLANK = 32'h2020_2020;
  localparam logic [31:0] OVERLOAD_PICKUP_WARNING_CODE = 32'h4C4F_4144;
  localparam logic [31:0] LONG_DELAY_TRIP_CODE = 32'h4C4F_4E47;
  localparam logic [31:0] SHORT_DELAY_TRIP_CODE = 32'h5348_5254;
  localparam logic [31:0] INSTANT_TRIP_CODE = 32'h494E_5354;
  localparam logic [31:0] GROUND_FAULT_TRIP_CODE = 32'h4752_4E44;
  localparam logic [31:0] DISCRIMINATOR_TRIP_CODE = 32'h4449_5343;
  localparam logic [31:0] OVERRIDE_TRIP_CODE = 32'h4F56_5244;
  localparam logic [31:0] OVER_RANGE_CODE = 32'h5247_4F56;
  localparam logic [31:0] TEST_CODE = 32'h5445_5354;
  localparam logic [31:0] PLUG_FAULT_CODE = 32'h504C_5547;
  localparam logic [31:0] DATA_MEM_FAULT_CODE = 32'h4452_414D;
  localparam logic [31:0] PROG_MEM_FAULT_CODE = 32'h5052_4F4D;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  // Trip cause, one bit each, as raised by the protection side
  typedef struct packed {
    logic long_delay;
    logic short_delay;
    logic instant;
    logic ground;
    logic discrim;
    logic override_trip;
  } tca_cause_s;

  localparam tca_cause_s CAUSE_NONE = '{default: 1'b0};

  // Current pointer position
  typedef enum logic [3:0] {
    PTR_CODE = 4'b0001,
    PTR_A    = 4'b0010,
    PTR_B    = 4'b0100,
    PTR_C    = 4'b1000
  } tca_ptr_e;

endpackage

// ---- tca_button.sv ----
// Purpose: Debounce one pushbutton and give a single press pulse
// Assumes: Raw input is asynchronous to clock
// Notes: A press is reported once the level has been stable low-to-high
`timescale 1ns/1ps
module tca_button
  import tca_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = DEBOUNCE_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic raw,
  output logic pressed,
  output logic press
);

  // -------------------------------------------------------------
  // Synchroniser and filter
  // -------------------------------------------------------------
  logic sync_a;          // First stage, read only by sync_b
  logic sync_b;          // Second stage
  logic [31:0] count;    // Stability counter
  wire stable_done = (count >= SETTLE_CYC - 1);
  wire differs = (sync_b != pressed);

  // Two flops before anything looks at the pin
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end

  // Level must hold for the whole settle time to be accepted
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h0000_0000;
      pressed <= 1'b0;
      press <= 1'b0;
    end else begin
      press <= 1'b0;
      if (!differs) begin
        count <= 32'h0000_0000;
      end else if (stable_done) begin
        count <= 32'h0000_0000;
        pressed <= sync_b;
        press <= sync_b;
      end else begin
        count <= count + 32'h0000_0001;
      end
    end
  end

  one_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    press |=> !press) else $error("press lasted more than one cycle");

endmodule // tca_button

// ---- tca_annunciator.sv ----
// Purpose: Trip cause annunciator: codes, frozen currents, LEDs, relays
// Assumes: Protection side gives one-cycle trip pulses and current words
// Notes: Buttons are raw pins; all other inputs are on clock
//
// Summary of operation
// - Trip shows distinct cause code per function
// - Pickup without trip shows overload warning
// - Discriminator trip shows its own code
// - Override trip shows its own code
// - Override detected near hundred times rating
// - Test code shown while test button held
// - Test code removed on button release
// - Test code only for full trip tests
// - Rating plug problem shows plug code
// - Data memory failure shows its code
// - Program memory failure shows its code
// - Reset reruns memory self-tests
// - Override trips on partial current value
// - Override interrogation shows over-range code; here only if the peak phase at trip reached accuracy_limit
// - Cause code latched until step press
// - Trip currents frozen until trip reset
// - Long-delay trip lights LED, shows code
// - Long-delay trip closes long-delay relay
// - Step walks phases A, B, C currents
// - Reset clears codes, currents, LED
`timescale 1ns/1ps
module tca_annunciator
  import tca_pkg::*;
#(
  parameter int unsigned CUR_W = 16,            // Current word width
  parameter int unsigned SETTLE_CYC = DEBOUNCE_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire tca_cause_s trip_cause,            // One-cycle trip pulses
  input wire logic overload_pickup,             // Above long-delay pickup
  input wire logic [CUR_W-1:0] current_a,       // Running RMS, phase A
  input wire logic [CUR_W-1:0] current_b,
  input wire logic [CUR_W-1:0] current_c,
  input wire logic [CUR_W-1:0] current_g,
  input wire logic [CUR_W-1:0] rating,          // Frame or sensor rating
  input wire logic [CUR_W-1:0] accuracy_limit,  // Top of sensor range
  input wire logic plug_fault,
  input wire logic data_mem_fail,
  input wire logic prog_mem_fail,
  input wire logic selftest_done,               // One-cycle result strobe
  input wire logic phase_trip_test_select,
  input wire logic ground_trip_test_select,
  input wire logic test_button_raw,
  input wire logic step_button_raw,
  input wire logic reset_button_raw,
  output logic [31:0] display_code,             // Four ASCII characters
  output logic display_is_code,                 // 1 code, 0 numeric
  output logic [CUR_W-1:0] display_value,
  output tca_ptr_e pointer,
  output tca_cause_s cause_led,
  output logic long_delay_relay,
  output logic short_circuit_relay,
  output logic ground_relay,
  output logic override_detect,                 // Override level reached
  output logic selftest_start,                  // Rerun memory tests
  output logic [CUR_W-1:0] frozen_g
);

  // -------------------------------------------------------------
  // Buttons
  // -------------------------------------------------------------
  logic test_held;   // Debounced test level
  logic step_press;  // One pulse per step press
  logic reset_press; // One pulse per reset press

  // Test is read as a held level, step and reset as single pulses; each
  // pin has its own filter so a bouncing contact never moves another
  tca_button #(.SETTLE_CYC(SETTLE_CYC)) u_test (
    .clock(clock), .rst_n(rst_n), .raw(test_button_raw),
    .pressed(test_held), .press());
  tca_button #(.SETTLE_CYC(SETTLE_CYC)) u_step (
    .clock(clock), .rst_n(rst_n), .raw(step_button_raw),
    .pressed(), .press(step_press));
  tca_button #(.SETTLE_CYC(SETTLE_CYC)) u_reset (
    .clock(clock), .rst_n(rst_n), .raw(reset_button_raw),
    .pressed(), .press(reset_press));

  // -------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------
  logic tripped;                 // A trip is on record
  tca_cause_s cause;             // Latched cause
  logic [CUR_W-1:0] frz_a;
  logic [CUR_W-1:0] frz_b;
  logic [CUR_W-1:0] frz_c;
  logic over_range;              // Override beyond sensor range
  tca_ptr_e next_pointer;
  logic [CUR_W+7:0] override_level;
  logic [CUR_W:0] peak;

  wire any_trip = |trip_cause;
  // Override threshold scaled by the fixed multiple; the product is exact,
  // so any tolerance around the nominal level must come in on the rating
  // word. The eight extra bits keep a full-scale rating from wrapping.
  assign override_level = rating * 8'(OVERRIDE_MULT);
  // Largest phase, used for range check
  assign peak = {1'b0, (current_a > current_b) ?
                 ((current_a > current_c) ? current_a : current_c) :
                 ((current_b > current_c) ? current_b : current_c)};
  assign override_detect = ({8'h00, peak[CUR_W-1:0]} >= override_level);
  wire full_test = phase_trip_test_select | ground_trip_test_select;
  wire show_test = test_held & full_test;

  // Cause code chosen by priority, most severe first
  wire [31:0] cause_code =
    cause.override_trip ? OVERRIDE_TRIP_CODE :
    cause.discrim       ? DISCRIMINATOR_TRIP_CODE :
    cause.instant       ? INSTANT_TRIP_CODE :
    cause.short_delay   ? SHORT_DELAY_TRIP_CODE :
    cause.ground        ? GROUND_FAULT_TRIP_CODE :
    LONG_DELAY_TRIP_CODE;

  // Step sequence: code, A, B, C, then back to A
  always_comb begin
    next_pointer = pointer;
    unique case (pointer)
      PTR_CODE: next_pointer = PTR_A;
      PTR_A:    next_pointer = PTR_B;
      PTR_B:    next_pointer = PTR_C;
      PTR_C:    next_pointer = PTR_A;
      default:  next_pointer = PTR_CODE;
    endcase
  end

  // -------------------------------------------------------------
  // Trip record
  // -------------------------------------------------------------
  // A trip freezes the running value, which may be partial on fast
  // trips; reset wins over a new trip so the operator always clears
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tripped <= 1'b0;
      cause <= CAUSE_NONE;
      over_range <= 1'b0;
      frz_a <= '0;
      frz_b <= '0;
      frz_c <= '0;
      frozen_g <= '0;
    end else if (reset_press) begin
      tripped <= 1'b0;
      cause <= CAUSE_NONE;
      over_range <= 1'b0;
      frz_a <= '0;
      frz_b <= '0;
      frz_c <= '0;
      frozen_g <= '0;
    end else if (any_trip && !tripped) begin
      tripped <= 1'b1;
      cause <= trip_cause;
      over_range <= (peak[CUR_W-1:0] >= accuracy_limit);
      frz_a <= current_a;
      frz_b <= current_b;
      frz_c <= current_c;
      frozen_g <= current_g;
    end
  end

  // Pointer parks on the code until step, then walks phases
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pointer <= PTR_CODE;
    end else if (reset_press || (any_trip && !tripped)) begin
      pointer <= PTR_CODE;
    end else if (step_press && tripped) begin
      pointer <= next_pointer;
    end
  end

  // -------------------------------------------------------------
  // Self-test rerun and fault latches
  // -------------------------------------------------------------
  logic data_fault;
  logic prog_fault;

  // Reset request kicks a fresh memory test. A result strobe in the same
  // cycle as a reset press wins, so a failing memory is never hidden
  // by the clear that the reset itself causes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      selftest_start <= 1'b0;
      data_fault <= 1'b0;
      prog_fault <= 1'b0;
    end else begin
      selftest_start <= reset_press;
      if (selftest_done) begin
        data_fault <= data_mem_fail;
        prog_fault <= prog_mem_fail;
      end else if (reset_press) begin
        data_fault <= 1'b0;
        prog_fault <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // Display selection
  // -------------------------------------------------------------
  // Trip record outranks the test message and trouble codes
  wire [CUR_W-1:0] phase_val = (pointer == PTR_A) ? frz_a :
                               (pointer == PTR_B) ? frz_b : frz_c;
  wire code_shown = tripped && (pointer == PTR_CODE);
  wire ovr_shown = tripped && !code_shown && cause.override_trip && over_range;
  wire [31:0] next_code =
    code_shown    ? cause_code :
    ovr_shown     ? OVER_RANGE_CODE :
    tripped       ? CODE_BLANK :
    show_test     ? TEST_CODE :
    prog_fault    ? PROG_MEM_FAULT_CODE :
    data_fault    ? DATA_MEM_FAULT_CODE :
    plug_fault    ? PLUG_FAULT_CODE :
    overload_pickup ? OVERLOAD_PICKUP_WARNING_CODE :
    CODE_BLANK;
  wire next_is_code = !(tripped && !code_shown && !ovr_shown);

  // Registered display drive; the numeric word is forced to zero while a
  // code is up so a stale current never shows beside a message
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      display_code <= CODE_BLANK;
      display_is_code <= 1'b1;
      display_value <= '0;
    end else begin
      display_code <= next_code;
      display_is_code <= next_is_code;
      display_value <= next_is_code ? '0 : phase_val;
    end
  end

  // -------------------------------------------------------------
  // LEDs and relays
  // -------------------------------------------------------------
  // Indicators follow the latched cause, so reset drops them all
  // The short circuit relay gathers every fast trip cause
  assign cause_led = cause;
  assign long_delay_relay = cause.long_delay;
  assign short_circuit_relay = cause.short_delay | cause.instant |
                               cause.discrim | cause.override_trip;
  assign ground_relay = cause.ground;

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  // Cause code stays up until the operator steps or resets
  code_latched_a: assert property (@(posedge clock) disable iff (!rst_n)
    (code_shown && !step_press && !reset_press) |=> code_shown)
    else $error("cause code dropped without step");
  // Compared with the cause as latched, so a reset right after a trip is legal
  trip_shows_a: assert property (@(posedge clock) disable iff (!rst_n)
    (any_trip && !tripped && !reset_press) |=> ##1 (display_code == $past(cause_code)))
    else $error("trip did not show cause code");
  ld_relay_a: assert property (@(posedge clock) disable iff (!rst_n)
    (trip_cause.long_delay && !tripped && !reset_press) |=>
    (long_delay_relay && cause_led.long_delay))
    else $error("long delay relay or led not set");
  reset_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    reset_press |=> (!tripped && cause_led == CAUSE_NONE && !long_delay_relay))
    else $error("reset did not clear record");
  frozen_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (tripped && !reset_press) |=> $stable(frz_a) && $stable(frozen_g))
    else $error("frozen current moved");
  test_show_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!tripped && show_test && !$past(tripped)) |=> (display_code == TEST_CODE))
    else $error("test code missing");
  test_gone_a: assert property (@(posedge clock) disable iff (!rst_n)
    !test_held |=> (display_code != TEST_CODE))
    else $error("test code stayed after release");
  selftest_a: assert property (@(posedge clock) disable iff (!rst_n)
    reset_press |=> selftest_start)
    else $error("reset did not rerun self-test");
  step_walk_a: assert property (@(posedge clock) disable iff (!rst_n)
    (tripped && pointer == PTR_A && step_press && !reset_press && !any_trip)
    |=> pointer == PTR_B)
    else $error("step did not advance pointer");
  // Override interrogation beyond sensor range shows the over-range code, never a number
  range_show_a: assert property (@(posedge clock) disable iff (!rst_n)
    (tripped && cause.override_trip && over_range && pointer != PTR_CODE)
    |=> (display_code == OVER_RANGE_CODE && display_is_code))
    else $error("over-range code not shown");
  mem_latch_a: assert property (@(posedge clock) disable iff (!rst_n)
    selftest_done |=> (data_fault == $past(data_mem_fail) &&
    prog_fault == $past(prog_mem_fail)))
    else $error("memory test result not latched");
  warn_show_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!tripped && !show_test && !prog_fault && !data_fault && !plug_fault &&
    overload_pickup) |=> (display_code == OVERLOAD_PICKUP_WARNING_CODE))
    else $error("overload warning not shown");
  pointer_onehot_a: assert property (@(posedge clock) disable iff (!rst_n)
    $onehot(pointer))
    else $error("pointer lost its single position");

  // Main scenarios the bench is expected to reach
  trip_seen_c: cover property (@(posedge clock) disable iff (!rst_n)
    any_trip && !tripped);
  walk_c_c: cover property (@(posedge clock) disable iff (!rst_n)
    tripped && pointer == PTR_C);
  over_range_c: cover property (@(posedge clock) disable iff (!rst_n)
    display_code == OVER_RANGE_CODE);
  test_c: cover property (@(posedge clock) disable iff (!rst_n)
    display_code == TEST_CODE);
  mem_fault_c: cover property (@(posedge clock) disable iff (!rst_n)
    display_code == DATA_MEM_FAULT_CODE);

endmodule // tca_annunciator

// ---- tca_operator.sv ----
// Purpose: Operator model that works the test, step and reset pushbuttons
// Assumes: Bench asks for a button by holding its want bit high
// Notes: Every press bounces once, so a weak debounce shows as a double step
`timescale 1ns/1ps
module tca_operator (
  input wire logic clock,
  input wire logic [2:0] want, // Requests: test, step, reset
  output logic [2:0] raw // Contact levels seen at the pins
);
  // ---------------------------------------------------------------
  // Contact bounce
  // ---------------------------------------------------------------
  logic [2:0] hist_0; // Request one cycle ago
  logic [2:0] hist_1; // Request two cycles ago

  // History of each request, used to time the bounce
  always_ff @(posedge clock) begin
    hist_0 <= want;
    hist_1 <= hist_0;
  end

  // Contact opens for one cycle right after closing, like a real switch
  assign raw = want & ~(hist_0 & ~hist_1);
endmodule // tca_operator

// ---- trip_cause_annunciator_test.sv ----
// Purpose: Self-checking bench for the trip cause annunciator
// Assumes: Short debounce count so each press takes a few dozen cycles
// Notes: Random phase currents from a fixed seed, corner cases by hand
`timescale 1ns/1ps
module trip_cause_annunciator_test;
  import tca_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int unsigned SETTLE = 4; // Debounce count kept short in sim
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  tca_cause_s trip_cause = CAUSE_NONE; // One-cycle trip pulses
  logic overload_pickup = 1'b0;
  logic [15:0] cur [4] = '{default: 16'h0000}; // Phases A, B, C, ground
  logic [15:0] frz [4]; // Currents the unit should freeze
  logic [15:0] rating = 16'h000A; // Override level is then 1000
  logic [15:0] accuracy_limit = 16'h7000;
  logic plug_fault = 1'b0;
  logic [1:0] mem_fail = 2'b00; // Program fail, data fail
  logic selftest_done = 1'b0;
  logic [1:0] test_sel = 2'b00; // Phase test, ground test
  logic [2:0] want = 3'b000; // Operator requests: test, step, reset
  logic [2:0] raw; // Bounced button pins
  logic [31:0] display_code;
  logic display_is_code;
  logic [15:0] display_value;
  tca_ptr_e pointer;
  tca_cause_s cause_led;
  logic long_delay_relay;
  logic short_circuit_relay;
  logic ground_relay;
  logic override_detect;
  logic selftest_start;
  logic [15:0] frozen_g;
  int n_mismatch = 0;
  int checked = 0;
  tca_ptr_e ptr_tab [3] = '{PTR_A, PTR_B, PTR_C}; // Step order

  always #5 clock = ~clock;

  tca_operator partner (.clock(clock), .want(want), .raw(raw));

  tca_annunciator #(.CUR_W(16), .SETTLE_CYC(SETTLE)) uut (
    .clock(clock), .rst_n(rst_n), .trip_cause(trip_cause),
    .overload_pickup(overload_pickup), .current_a(cur[0]), .current_b(cur[1]),
    .current_c(cur[2]), .current_g(cur[3]), .rating(rating),
    .accuracy_limit(accuracy_limit), .plug_fault(plug_fault),
    .data_mem_fail(mem_fail[0]), .prog_mem_fail(mem_fail[1]),
    .selftest_done(selftest_done), .phase_trip_test_select(test_sel[1]),
    .ground_trip_test_select(test_sel[0]), .test_button_raw(raw[2]),
    .step_button_raw(raw[1]), .reset_button_raw(raw[0]),
    .display_code(display_code), .display_is_code(display_is_code),
    .display_value(display_value), .pointer(pointer), .cause_led(cause_led),
    .long_delay_relay(long_delay_relay), .short_circuit_relay(short_circuit_relay),
    .ground_relay(ground_relay), .override_detect(override_detect),
    .selftest_start(selftest_start), .frozen_g(frozen_g));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Cause order: long, short, instant, ground, discriminator, override
  function automatic logic [31:0] exp_code(input int i);
    logic [31:0] tab [6];
    tab = '{LONG_DELAY_TRIP_CODE, SHORT_DELAY_TRIP_CODE, INSTANT_TRIP_CODE,
            GROUND_FAULT_TRIP_CODE, DISCRIMINATOR_TRIP_CODE, OVERRIDE_TRIP_CODE};
    return tab[i];
  endfunction

  // Compare with four-state equality so an unknown never matches
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Let n edges pass, then step off the edge so outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // One full press and release, long enough for sync plus debounce
  task automatic press(input int b);
    @(posedge clock) want[b] <= 1'b1;
    tick(14);
    @(posedge clock) want[b] <= 1'b0;
    tick(14);
  endtask

  // Trip reset press; self-test request must follow within a bound
  task automatic reset_press;
    int k;
    @(posedge clock) want[0] <= 1'b1;
    for (k = 0; k < 30 && selftest_start !== 1'b1; k++) tick(1);
    if (k == 30) begin
      n_mismatch++;
      $display("BAD selftest_start expected 1 seen 0");
      tally_and_finish();
    end
    tick(10);
    @(posedge clock) want[0] <= 1'b0;
    tick(14);
  endtask

  // Self-test result strobe, one cycle wide
  task automatic pulse_done;
    @(posedge clock) selftest_done <= 1'b1;
    @(posedge clock) selftest_done <= 1'b0;
    tick(3);
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(37));
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    tick(1);
    chk("display_code", CODE_BLANK, display_code);
    // Every cause once; override last with phase B above sensor range
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      // Override trip gets phase B above the sensor range for the over-range case
      foreach (cur[p]) cur[p] <= (i == 5 && p == 1) ? 16'h7100 : 16'($urandom_range(16'h0FFF));
      trip_cause <= tca_cause_s'(6'h20 >> i);
      @(posedge clock) trip_cause <= CAUSE_NONE;
      frz = cur;
      tick(2);
      chk("display_code", exp_code(i), display_code);
      chk("cause_led", 32'(6'h20 >> i), 32'(cause_led));
      chk("long_delay_relay", 32'(i == 0), 32'(long_delay_relay));
      chk("short_circuit_relay", 32'(i != 0 && i != 3), 32'(short_circuit_relay));
      chk("ground_relay", 32'(i == 3), 32'(ground_relay));
      // Later trip and new currents must not disturb the record
      @(posedge clock);
      foreach (cur[p]) cur[p] <= 16'($urandom_range(16'h0FFF));
      trip_cause <= tca_cause_s'(6'h20 >> ((i + 1) % 6));
      @(posedge clock) trip_cause <= CAUSE_NONE;
      tick(3);
      chk("held code", exp_code(i), display_code);
      chk("held led", 32'(6'h20 >> i), 32'(cause_led));
      for (int s = 0; s < 4; s++) begin
        press(1);
        chk("pointer", 32'(ptr_tab[s % 3]), 32'(pointer));
        if (i == 5) begin
          chk("over range", OVER_RANGE_CODE, display_code);
        end else begin
          chk("is_code", 32'h0000_0000, 32'(display_is_code));
          chk("value", 32'(frz[s % 3]), 32'(display_value));
        end
      end
      chk("frozen_g", 32'(frz[3]), 32'(frozen_g));
      reset_press();
      chk("cleared code", CODE_BLANK, display_code);
      chk("cleared led", 32'h0000_0000, 32'(cause_led));
      chk("pointer home", 32'(PTR_CODE), 32'(pointer));
    end
    $display("Test trips done");
    // Override level: one count below and at a hundred times rating
    @(posedge clock) cur <= '{16'h0000, 16'h0000, 16'h03E7, 16'h0000};
    tick(1);
    chk("override_detect", 32'h0000_0000, 32'(override_detect));
    @(posedge clock) cur[2] <= 16'h03E8;
    tick(1);
    chk("override_detect", 32'h0000_0001, 32'(override_detect));
    // Warning and plug levels
    @(posedge clock) overload_pickup <= 1'b1;
    tick(3);
    chk("warning", OVERLOAD_PICKUP_WARNING_CODE, display_code);
    @(posedge clock) overload_pickup <= 1'b0;
    plug_fault <= 1'b1;
    tick(3);
    chk("plug", PLUG_FAULT_CODE, display_code);
    @(posedge clock) plug_fault <= 1'b0;
    $display("Test levels done");
    // Test code: phase test, ground test, then no test selected
    for (int t = 0; t < 3; t++) begin
      @(posedge clock) test_sel <= 2'b10 >> t;
      press_hold: begin
        @(posedge clock) want[2] <= 1'b1;
        tick(14);
        chk("test shown", 32'(t < 2), 32'(display_code === TEST_CODE));
        @(posedge clock) want[2] <= 1'b0;
        tick(14);
        chk("test removed", 32'h0000_0000, 32'(display_code === TEST_CODE));
      end
    end
    $display("Test code done");
    // Memory faults persist across trip reset once the tests rerun
    for (int k = 0; k < 2; k++) begin
      @(posedge clock) mem_fail <= 2'b01 << k;
      pulse_done();
      chk("mem code", k ? PROG_MEM_FAULT_CODE : DATA_MEM_FAULT_CODE, display_code);
      reset_press();
      pulse_done();
      chk("mem again", k ? PROG_MEM_FAULT_CODE : DATA_MEM_FAULT_CODE, display_code);
      @(posedge clock) mem_fail <= 2'b00;
      pulse_done();
      chk("mem clear", CODE_BLANK, display_code);
    end
    $display("Test memory done");
    tally_and_finish();
  end
endmodule // trip_cause_annunciator_test
